/* File: core/rtcx_defines.svh */
// Purpose: Offsets, field positions, reset values and codes of the RTC
//          status and calendar-extension block.
// Assumes: Register index times four gives the byte address.
// Notes:   Header of definitions only.
`ifndef RTCX_DEFINES_SVH
`define RTCX_DEFINES_SVH

// ----------------------------------------
// Register indices
// ----------------------------------------
`define RTCX_IDX_HALT     6'h01
`define RTCX_IDX_DATE     6'h05
`define RTCX_IDX_CMONTH   6'h06
`define RTCX_IDX_YEAR     6'h07
`define RTCX_IDX_CALIB    6'h08
`define RTCX_IDX_WDOG     6'h09
`define RTCX_IDX_ALARMCTL 6'h0a
`define RTCX_IDX_OFCTL    6'h0b
`define RTCX_IDX_FLAGS    6'h0f

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RTCX_BIT_HALT     7
`define RTCX_BIT_OUT      7
`define RTCX_BIT_AFE      7
`define RTCX_BIT_OSC_FAIL_IRQ_EN     7
`define RTCX_BIT_WDF      7
`define RTCX_BIT_AF       6
`define RTCX_BIT_OF       2
`define RTCX_CENT_HI      7
`define RTCX_CENT_LO      6

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RTCX_RST_DATE     8'h01
`define RTCX_RST_MONTH    5'h01
`define RTCX_RST_YEAR     8'h00
`define RTCX_RST_CALIB    8'h80
`define RTCX_WD_RES_MAX   3'h4
`define RTCX_MONTH_FEB    5'h02
`define RTCX_MONTH_DEC    5'h12
`define RTCX_YEAR_LAST    8'h99

`endif

/* File: core/rtcx_pkg.sv */
// Purpose: Types shared by the RTC status and calendar-extension block.
// Assumes: Calendar fields held in BCD.
// Notes:   Offsets and counts live in rtcx_defines.svh.
package rtcx_pkg;

    // Calendar state carried between the calendar and the register file
    typedef struct packed {
        logic [1:0] century;
        logic [4:0] month;
        logic [7:0] date;
        logic [7:0] year;
    } rtcx_cal_type;

    // Calendar field chosen by a register write
    typedef enum logic [1:0] {
        rtcx_sel_date,
        rtcx_sel_cmonth,
        rtcx_sel_year
    } rtcx_sel_type;

endpackage

/* File: core/rtcx_osc_mon.sv */
// Purpose: Oscillator-fail flag keeping.
// Assumes: Stop and low-supply indications are synchronous levels.
// Notes:   Any set cause beats a software clear in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "rtcx_defines.svh"
module rtcx_osc_mon
    import rtcx_pkg::*;
(
    input  wire logic clock,        // System clock
    input  wire logic nrst,         // Async reset, active low
    input  wire logic osc_stopped,  // Oscillator not running
    input  wire logic supply_low,   // Supply too low to oscillate
    input  wire logic halt,         // Software stop bit
    input  wire logic clear_of,     // Software wrote 0 to the flag
    output logic      osc_fail      // Oscillator-fail flag
);

    logic set_cause;

    // Any reason the oscillator is not running
    assign set_cause = osc_stopped | supply_low | halt;

    // ----------------------------------------
    // Flag register
    // ----------------------------------------
    // power-up set
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            osc_fail <= 1'b1;
        end else if (set_cause) begin
            osc_fail <= 1'b1;
        end else if (clear_of) begin
            osc_fail <= 1'b0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_stop_sets;
        osc_stopped || supply_low |=> osc_fail;
    endproperty
    a_stop_sets: assert property (p_stop_sets) else $error("stop did not set flag");

    property p_halt_sets;
        halt |=> osc_fail;
    endproperty
    a_halt_sets: assert property (p_halt_sets) else $error("halt did not set flag");

    property p_flag_sticky;
        osc_fail && !clear_of |=> osc_fail;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped alone");

endmodule
`default_nettype wire

/* File: core/rtcx_calendar.sv */
// Purpose: Date, month, year and century counting in BCD.
// Assumes: day_tick pulses once per midnight from the time-of-day logic.
// Notes:   Leap day in every year divisible by 4, century years included.
`timescale 1ns/10ps
`default_nettype none
`include "rtcx_defines.svh"
module rtcx_calendar
    import rtcx_pkg::*;
(
    input  wire logic         clock,    // System clock
    input  wire logic         nrst,     // Async reset, active low
    input  wire logic         day_tick, // Midnight pulse
    input  wire logic         wr_en,    // Software write strobe
    input  wire rtcx_sel_type wr_sel,   // Field written
    input  wire logic [7:0]   wr_data,  // Write data
    output rtcx_cal_type      cal       // Calendar state
);

    // BCD year divisible by 4
    function automatic logic leap(input logic [7:0] y);
        logic [3:0] u;
        u = y[3:0];
        if (y[4])
            leap = (u == 4'h2) || (u == 4'h6);
        else
            leap = (u == 4'h0) || (u == 4'h4) || (u == 4'h8);
    endfunction

    // Last date of a month in BCD
    function automatic logic [7:0] last_day(input logic [4:0] m, input logic lp);
        unique case (m)
            5'h02:                      last_day = lp ? 8'h29 : 8'h28;
            5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
            default:                    last_day = 8'h31;
        endcase
    endfunction

    // BCD increment of one byte
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9)
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        else
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
    endfunction

    logic end_month;
    logic end_year;

    assign end_month = cal.date == last_day(cal.month, leap(cal.year));
    assign end_year  = end_month && (cal.month == `RTCX_MONTH_DEC);

    // ----------------------------------------
    // Counting and software loads
    // ----------------------------------------
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cal.century <= 2'h0;
            cal.month   <= `RTCX_RST_MONTH;
            cal.date    <= `RTCX_RST_DATE;
            cal.year    <= `RTCX_RST_YEAR;
        end else if (wr_en) begin
            unique case (wr_sel)
                rtcx_sel_date:   cal.date <= wr_data;
                rtcx_sel_cmonth: begin
                    cal.century <= wr_data[`RTCX_CENT_HI:`RTCX_CENT_LO];
                    cal.month   <= wr_data[4:0];
                end
                rtcx_sel_year:   cal.year <= wr_data;
                default:         cal.year <= cal.year;
            endcase
        end else if (day_tick) begin
            cal.date <= end_month ? 8'h01 : bcd_inc(cal.date);
            if (end_month)
                cal.month <= end_year ? 5'h01 : 5'(bcd_inc({3'h0, cal.month}));
            if (end_year) begin
                cal.year <= (cal.year == `RTCX_YEAR_LAST) ? 8'h00 : bcd_inc(cal.year);
                if (cal.year == `RTCX_YEAR_LAST)
                    cal.century <= cal.century + 2'h1;
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_century;
        day_tick && !wr_en && end_year && cal.year == 8'h99
            |=> cal.century == $past(cal.century) + 2'h1 && cal.year == 8'h00;
    endproperty
    a_century: assert property (p_century) else $error("century not advanced");

    property p_leap;
        day_tick && !wr_en && cal.month == 5'h02 && cal.date == 8'h28 && leap(cal.year)
            |=> cal.date == 8'h29;
    endproperty
    a_leap: assert property (p_leap) else $error("leap day skipped");

    property p_year_load;
        wr_en && wr_sel == rtcx_sel_year |=> cal.year == $past(wr_data);
    endproperty
    a_year_load: assert property (p_year_load) else $error("year not loaded");

    c_century: cover property (day_tick && end_year && cal.year == 8'h99);
    c_feb29: cover property (day_tick && cal.month == 5'h02 && cal.date == 8'h29);

endmodule
`default_nettype wire

/* File: core/rtcx_top.sv */
// Purpose: Status and calendar extension of a real-time clock: century
//          count, leap day, oscillator-fail flag and shared interrupt or
//          general output pin, behind an Avalon-MM slave.
// Assumes: Alarm and watchdog flags come from neighbouring logic.
// Notes:   One answer cycle per access; open-drain pin as out/oe pair.
//
// Operation
// - Two-bit century counter above month field
// - Year held in BCD, century above it
// - February 29 in every fourth year
// - No source enabled: pin follows level bit
// - Level bit 0 pulls low, 1 releases
// - Oscillator stop sets fail flag
// - Fail flag set at power-up
// - Stop bit set sets fail flag
// - Flag and enable assert interrupt pin
// - Only clearing flag or enable releases
// - Flag stays until written zero
// - Stop during power-down still recorded
// - Undefaulted bits need host initialisation
// - Oscillator runs only while stop clear
// - Watchdog value zero disables source
`timescale 1ns/10ps
`default_nettype none
`include "rtcx_defines.svh"
module rtcx_top
    import rtcx_pkg::*;
(
    input  wire logic        clock,         // 25 MHz system clock
    input  wire logic        nrst,          // Async reset, active low
    input  wire logic [7:0]  address,       // Avalon byte address
    input  wire logic        read,          // Avalon read
    input  wire logic        write,         // Avalon write
    input  wire logic [31:0] writedata,     // Avalon write data
    input  wire logic [3:0]  byteenable,    // Avalon byte enables
    output logic [31:0]      readdata,      // Avalon read data
    output logic             waitrequest,   // Avalon wait
    input  wire logic        day_tick,      // Midnight pulse
    input  wire logic        osc_stopped,   // Oscillator stop detect
    input  wire logic        supply_low,    // Supply below oscillation
    input  wire logic        alarm_flag,    // Alarm pending
    input  wire logic        wdog_flag,     // Watchdog timed out
    output logic             osc_run,       // Oscillator run enable
    output logic             irq_out,       // Pin drive value, always 0
    output logic             irq_oe         // Pin pulled low when high
);

    // ----------------------------------------
    // Decode helpers
    // ----------------------------------------

    // Watchdog value that can raise a timeout
    function automatic logic wd_live(input logic [7:0] w);
        wd_live = (w != 8'h00) && ({w[7], w[1:0]} <= `RTCX_WD_RES_MAX);
    endfunction

    // Register index of a byte address
    function automatic logic [5:0] reg_idx(input logic [7:0] a);
        reg_idx = a[7:2];
    endfunction

    logic         ack;
    logic         wr_ok;
    logic         rd_ok;
    logic [5:0]   idx;
    logic [7:0]   wbyte;
    logic         halt;
    logic         out_level;
    logic         alarm_irq_en;
    logic         osc_fail_irq_en;
    logic [7:0]   wdog_value;
    logic         osc_fail_flag;
    logic         any_en;
    logic         pending;
    logic         next_irq_oe;
    logic         cal_wr;
    rtcx_sel_type cal_sel;
    rtcx_cal_type cal;
    logic [7:0]   next_rd;

    // ----------------------------------------
    // Bus handshake
    // ----------------------------------------

    // Accept an access in the cycle waitrequest is low
    assign idx   = reg_idx(address);
    assign wbyte = writedata[7:0];
    assign wr_ok = write && ack && byteenable[0] && (address[1:0] == 2'h0);
    assign rd_ok = read && ack;

    // One wait cycle, then answer; keeps readdata straight from a flop
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read || write) && !ack;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
        end else begin
            waitrequest <= !((read || write) && !ack);
        end
    end

    // ----------------------------------------
    // Control registers
    // ----------------------------------------

    // stop bit and enable reset clear
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            halt            <= 1'b0;
            osc_fail_irq_en <= 1'b0;
        end else if (wr_ok) begin
            if (idx == `RTCX_IDX_HALT)
                halt <= wbyte[`RTCX_BIT_HALT];
            if (idx == `RTCX_IDX_OFCTL)
                osc_fail_irq_en <= wbyte[`RTCX_BIT_OSC_FAIL_IRQ_EN];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            out_level    <= 1'(`RTCX_RST_CALIB >> `RTCX_BIT_OUT);
            alarm_irq_en <= 1'b0;
        end else if (wr_ok) begin
            if (idx == `RTCX_IDX_CALIB)
                out_level <= wbyte[`RTCX_BIT_OUT];
            if (idx == `RTCX_IDX_ALARMCTL)
                alarm_irq_en <= wbyte[`RTCX_BIT_AFE];
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wdog_value <= 8'h00;
        end else if (wr_ok && idx == `RTCX_IDX_WDOG) begin
            wdog_value <= wbyte;
        end
    end

    // ----------------------------------------
    // Calendar and oscillator monitor
    // ----------------------------------------

    // Route calendar writes
    always_comb begin
        cal_wr  = 1'b0;
        cal_sel = rtcx_sel_date;
        if (wr_ok) begin
            unique case (idx)
                `RTCX_IDX_DATE:   begin cal_wr = 1'b1; cal_sel = rtcx_sel_date;   end
                `RTCX_IDX_CMONTH: begin cal_wr = 1'b1; cal_sel = rtcx_sel_cmonth; end
                `RTCX_IDX_YEAR:   begin cal_wr = 1'b1; cal_sel = rtcx_sel_year;   end
                default:          cal_wr = 1'b0;
            endcase
        end
    end

    rtcx_calendar u_cal (
        .clock    (clock),
        .nrst     (nrst),
        .day_tick (day_tick),
        .wr_en    (cal_wr),
        .wr_sel   (cal_sel),
        .wr_data  (wbyte),
        .cal      (cal)
    );

    // host sequences rely on sticky flag
    rtcx_osc_mon u_osc (
        .clock       (clock),
        .nrst        (nrst),
        .osc_stopped (osc_stopped),
        .supply_low  (supply_low),
        .halt        (halt),
        .clear_of    (wr_ok && idx == `RTCX_IDX_FLAGS && !wbyte[`RTCX_BIT_OF]),
        .osc_fail    (osc_fail_flag)
    );

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            osc_run <= 1'b0;
        end else begin
            osc_run <= !halt;
        end
    end

    // ----------------------------------------
    // Interrupt or output pin
    // ----------------------------------------

    assign any_en  = osc_fail_irq_en || alarm_irq_en || wd_live(wdog_value);
    assign pending = (osc_fail_flag && osc_fail_irq_en)
                  || (alarm_flag && alarm_irq_en)
                  || (wdog_flag && wd_live(wdog_value));

    assign next_irq_oe = any_en ? pending : !out_level;

    // Open drain: only ever pulls low
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            irq_oe  <= 1'b0;
            irq_out <= 1'b0;
        end else begin
            irq_oe  <= next_irq_oe;
            irq_out <= 1'b0;
        end
    end

    // ----------------------------------------
    // Read path
    // ----------------------------------------

    // Unmapped indices read as zero
    always_comb begin
        next_rd = 8'h00;
        unique case (idx)
            `RTCX_IDX_HALT:     next_rd = {halt, 7'h00};
            `RTCX_IDX_DATE:     next_rd = cal.date;
            `RTCX_IDX_CMONTH:   next_rd = {cal.century, 1'b0, cal.month};
            `RTCX_IDX_YEAR:     next_rd = cal.year;
            `RTCX_IDX_CALIB:    next_rd = {out_level, 7'h00};
            `RTCX_IDX_WDOG:     next_rd = wdog_value;
            `RTCX_IDX_ALARMCTL: next_rd = {alarm_irq_en, 7'h00};
            `RTCX_IDX_OFCTL:    next_rd = {osc_fail_irq_en, 7'h00};
            `RTCX_IDX_FLAGS:    next_rd = {wdog_flag, alarm_flag, 3'h0, osc_fail_flag, 2'h0};
            default:            next_rd = 8'h00;
        endcase
    end

    // Data captured one edge before the answer edge
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            readdata <= {24'h00_0000, next_rd};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    property p_idle_low;
        !any_en && !out_level |=> irq_oe;
    endproperty
    a_idle_low: assert property (p_idle_low) else $error("pin not pulled low");

    property p_idle_release;
        !any_en && out_level |=> !irq_oe;
    endproperty
    a_idle_release: assert property (p_idle_release) else $error("pin not released");

    property p_of_irq;
        osc_fail_flag && osc_fail_irq_en |=> irq_oe;
    endproperty
    a_of_irq: assert property (p_of_irq) else $error("fail irq missing");

    property p_read_keeps;
        osc_fail_flag && osc_fail_irq_en && rd_ok && idx == `RTCX_IDX_FLAGS && !write
            |=> ##1 irq_oe;
    endproperty
    a_read_keeps: assert property (p_read_keeps) else $error("read cleared irq");

    property p_alarm_irq;
        alarm_flag && alarm_irq_en |=> irq_oe;
    endproperty
    a_alarm_irq: assert property (p_alarm_irq) else $error("alarm irq missing");

    property p_halt_stops;
        wr_ok && idx == `RTCX_IDX_HALT && wbyte[`RTCX_BIT_HALT] |=> ##1 !osc_run;
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("osc still run");

    property p_wd_off;
        wr_ok && idx == `RTCX_IDX_WDOG && wbyte == 8'h00 |=> !wd_live(wdog_value);
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("watchdog still live");

    property p_answer;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("bad answer timing");

    c_of_irq: cover property (osc_fail_flag && osc_fail_irq_en ##1 irq_oe);
    c_out_pin: cover property (!any_en && !out_level ##1 irq_oe);
    c_wd_src: cover property (wdog_flag && wd_live(wdog_value));

endmodule
`default_nettype wire

/* File: dv/rtcx_host_model.sv */
// Purpose: Host microcontroller model, Avalon-MM master of the block.
// Assumes: One request at a time; the answer is awaited, never counted.
// Notes:   Flag-clear and oscillator-restart sequences of the host.
`timescale 1ns/10ps
`default_nettype none
`include "rtcx_defines.svh"
module rtcx_host_model
    import rtcx_pkg::*;
#(
    parameter int settle_cycles = 20 // Oscillator settle wait, shortened
)
(
    input  wire logic        clock,       // System clock
    output logic [7:0]       address,     // Byte address
    output logic             read,        // Read request
    output logic             write,       // Write request
    output logic [31:0]      writedata,   // Write data
    output logic [3:0]       byteenable,  // Byte lanes
    input  wire logic [31:0] readdata,    // Read data
    input  wire logic        waitrequest  // Slave wait
);
    // Idle bus at time zero
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h00000000;
        byteenable = 4'h1;
    end

    // ----------------------------------------
    // Bus cycles
    // ----------------------------------------
    // Request held until waitrequest is seen low at an edge
    task automatic bus_write(input logic [5:0] idx, input logic [7:0] d);
        @(posedge clock);
        address <= {idx, 2'b00};
        writedata <= {24'h000000, d};
        write <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask

    // Read data taken at the answer edge only
    task automatic bus_read(input logic [5:0] idx, output logic [7:0] d);
        @(posedge clock);
        address <= {idx, 2'b00};
        read <= 1'b1;
        do @(posedge clock); while (waitrequest !== 1'b0);
        d = readdata[7:0];
        read <= 1'b0;
    endtask

    // ----------------------------------------
    // Host sequences
    // ----------------------------------------
    // wait before clear
    task automatic clear_fail();
        repeat (settle_cycles) @(posedge clock);
        bus_write(`RTCX_IDX_FLAGS, 8'h00);
    endtask

    task automatic restart_osc();
        bus_write(`RTCX_IDX_HALT, 8'h80);
        bus_write(`RTCX_IDX_HALT, 8'h00);
    endtask
endmodule
`default_nettype wire

/* File: dv/tb_rtcx_top.sv */
// Purpose: Self-checking bench of the RTC status and calendar block.
// Assumes: Host model masters the bus; bench drives the status inputs.
// Notes:   Pin checked a few cycles after each cause has settled.
`timescale 1ns/10ps
`default_nettype none
`include "rtcx_defines.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb_rtcx_top
    import rtcx_pkg::*;
;
    logic        clock, nrst, read, write, waitrequest, day_tick;
    logic        osc_stopped, supply_low, alarm_flag, wdog_flag;
    logic        osc_run, irq_out, irq_oe;
    logic [7:0]  address, rd;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    int          mismatches, comparisons, cycle_count, i;

    // Clock, 40 ns period
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    rtcx_top dut (.clock(clock), .nrst(nrst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .day_tick(day_tick),
        .osc_stopped(osc_stopped), .supply_low(supply_low), .alarm_flag(alarm_flag),
        .wdog_flag(wdog_flag), .osc_run(osc_run), .irq_out(irq_out), .irq_oe(irq_oe));
    rtcx_host_model host (.clock(clock), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        host.bus_read(idx, rd);
        `CHK(rd, exp)
    endtask

    // Lets registered pin outputs land before sampling
    task automatic settle();
        repeat (3) @(posedge clock);
        #1;
    endtask

    task automatic pulse(input int which);
        @(posedge clock);
        osc_stopped <= (which == 0);
        supply_low <= (which == 1);
        day_tick <= (which == 2);
        @(posedge clock);
        {osc_stopped, supply_low, day_tick} <= 3'b000;
    endtask

    task automatic set_cal(input logic [7:0] cm, input logic [7:0] yr, input logic [7:0] dt);
        host.bus_write(`RTCX_IDX_CMONTH, cm);
        host.bus_write(`RTCX_IDX_YEAR, yr);
        host.bus_write(`RTCX_IDX_DATE, dt);
        pulse(2);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Hang guard, far above the few hundred cycles needed
    always @(posedge clock) begin
        cycle_count++;
        if (cycle_count == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {nrst, day_tick, osc_stopped, supply_low, alarm_flag, wdog_flag} = 6'h00;
        repeat (5) @(posedge clock);
        nrst <= 1'b1;
        settle();
        `CHK(osc_run, 1'b1)
        `CHK(irq_oe, 1'b0)
        `CHK(irq_out, 1'b0)
        rd_chk(`RTCX_IDX_FLAGS, 8'h04);
        rd_chk(`RTCX_IDX_CMONTH, 8'h01);
        rd_chk(6'h02, 8'h00);
        host.clear_fail();
        rd_chk(`RTCX_IDX_FLAGS, 8'h00);
        $display("test reset done");
        // Each stop cause: stop detect, low supply, stop bit
        for (i = 0; i < 3; i++) begin
            if (i == 2) host.bus_write(`RTCX_IDX_HALT, 8'h80);
            else pulse(i);
            rd_chk(`RTCX_IDX_FLAGS, 8'h04);
            rd_chk(`RTCX_IDX_FLAGS, 8'h04);
            if (i == 2) begin
                settle();
                `CHK(osc_run, 1'b0)
                host.restart_osc();
                settle();
                `CHK(osc_run, 1'b1)
            end
            host.clear_fail();
            rd_chk(`RTCX_IDX_FLAGS, 8'h00);
        end
        $display("test fail flag done");
        host.bus_write(`RTCX_IDX_OFCTL, 8'h80);
        settle();
        `CHK(irq_oe, 1'b0)
        pulse(0);
        settle();
        `CHK(irq_oe, 1'b1)
        rd_chk(`RTCX_IDX_FLAGS, 8'h04);
        settle();
        `CHK(irq_oe, 1'b1)
        host.clear_fail();
        settle();
        `CHK(irq_oe, 1'b0)
        pulse(1);
        settle();
        `CHK(irq_oe, 1'b1)
        host.bus_write(`RTCX_IDX_OFCTL, 8'h00);
        settle();
        `CHK(irq_oe, 1'b0)
        host.clear_fail();
        $display("test fail interrupt done");
        host.bus_write(`RTCX_IDX_CALIB, 8'h00);
        settle();
        `CHK(irq_oe, 1'b1)
        host.bus_write(`RTCX_IDX_ALARMCTL, 8'h80);
        settle();
        `CHK(irq_oe, 1'b0)
        @(posedge clock);
        alarm_flag <= 1'b1;
        settle();
        `CHK(irq_oe, 1'b1)
        @(posedge clock);
        alarm_flag <= 1'b0;
        host.bus_write(`RTCX_IDX_ALARMCTL, 8'h00);
        wdog_flag <= 1'b1;
        host.bus_write(`RTCX_IDX_WDOG, 8'h0e);
        settle();
        `CHK(irq_oe, 1'b1)
        @(posedge clock);
        wdog_flag <= 1'b0;
        settle();
        `CHK(irq_oe, 1'b0)
        host.bus_write(`RTCX_IDX_WDOG, 8'h00);
        settle();
        `CHK(irq_oe, 1'b1)
        host.bus_write(`RTCX_IDX_CALIB, 8'h80);
        settle();
        `CHK(irq_oe, 1'b0)
        $display("test output pin done");
        set_cal(8'h12, 8'h99, 8'h31);
        rd_chk(`RTCX_IDX_YEAR, 8'h00);
        rd_chk(`RTCX_IDX_CMONTH, 8'h41);
        set_cal(8'h42, 8'h00, 8'h28);
        rd_chk(`RTCX_IDX_DATE, 8'h29);
        pulse(2);
        rd_chk(`RTCX_IDX_CMONTH, 8'h43);
        set_cal(8'h42, 8'h01, 8'h28);
        rd_chk(`RTCX_IDX_DATE, 8'h01);
        $display("test calendar done");
        print_verdict();
    end
endmodule
`default_nettype wire
